// ### rtl/tpw_pkg.sv
// shared constants, field layouts and carrier types of the timer pwm block
package tpw_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] ADR_CTRL = 8'h00; // timer_control_reg
  localparam logic [7:0] ADR_DUTY = 8'h04; // duty_compare_reg
  localparam logic [7:0] ADR_STAT = 8'h08; // sticky event status, write one to clear
  localparam logic [7:0] ADR_MASK = 8'h0C; // interrupt mask, same layout as status
  localparam logic [7:0] ADR_CNT = 8'h10; // live counter, compare value and pin

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned CTRL_RUN_BIT = 0; // run_control_bit
  localparam int unsigned CTRL_CLK_LSB = 1; // source_clock_select, 3 bits
  localparam int unsigned CTRL_MODE_LSB = 4; // operating_mode_select, 3 bits
  localparam int unsigned STAT_OVF_BIT = 0; // overflow event
  localparam int unsigned CNT_SHIFT_LSB = 8; // compare value in the count word
  localparam int unsigned CNT_PIN_BIT = 16; // pin level in the count word

  // ==========================================================================
  // codes and reset values
  // ==========================================================================
  localparam logic [2:0] MODE_PWM = 3'h3; // operating mode that runs this block
  localparam logic [2:0] CLK_EXT = 3'h7; // external source, gives no tick here
  localparam logic [7:0] CNT_MAX = 8'hFF; // last count before the wrap
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00; // stopped after reset
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tpw_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tpw_wb_rsp_t;

  typedef enum logic [1:0] {
    PH_STOP,
    PH_HIGH,
    PH_LOW
  } tpw_phase_t;

  // prescaler depth per source clock code: one tick every 2**n mclk cycles
  function automatic logic [3:0] tpw_div_shift(input logic [2:0] sel);
    logic [3:0] n;
    n = 4'h0;
    case (sel)
      3'h0: n = 4'hC;
      3'h1: n = 4'h8;
      3'h2: n = 4'h6;
      3'h3: n = 4'h4;
      3'h4: n = 4'h3;
      3'h5: n = 4'h2;
      3'h6: n = 4'h1;
      default: n = 4'h0;
    endcase
    return n;
  endfunction

endpackage

// ### rtl/tpw_prescaler.sv
// source clock prescaler: turns mclk into the selected internal count tick
`timescale 1ns/1ps
module tpw_prescaler
  import tpw_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic en,
  input wire logic clear,
  input wire logic [2:0] sel,
  // tick to the counter
  output logic tick
);

  // ==========================================================================
  // divider
  // ==========================================================================
  logic [11:0] div_r;
  logic [11:0] div_nxt;
  logic [11:0] mask;

  // mask of low bits that must all be set for a tick
  assign mask = 12'((13'h0001 << tpw_div_shift(sel)) - 13'h0001);

  // external source code gives no tick, so the counter simply stands
  assign tick = en && !clear && (sel != CLK_EXT) && ((div_r & mask) == mask);

  // restart on clear so the first period has a full first tick
  always_comb begin
    div_nxt = div_r + 12'h001;
    if (clear || !en) begin
      div_nxt = 12'h000;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 12'h000;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  a_ext_no_tick: assert property (@(posedge mclk) disable iff (!nrst)
    (sel == CLK_EXT) |-> !tick)
    else $error("tick raised with external source selected");

endmodule

// ### rtl/tpw_top.sv
// pwm output mode of an 8-bit timer with a classic wishbone register slave
`timescale 1ns/1ps

// Notes on behaviour
// - in pwm mode an up-counter on the selected internal clock makes the wave, 8 bits of duty.
// - when the counter equals a nonzero active duty the output goes low and the counter keeps running.
// - on counter overflow the output returns high and the next period begins.
// - the timer interrupt is raised on overflow and never on the duty match.
// - while stopped the output is high; a stop during the low phase ends it at once.
// - comparison uses a shift register fed from the duty register, not the duty register itself.
// - a duty write during output moves to the shift register only at the end of the period.
// - setting the run bit to 1 loads the duty register into the shift register before period one.
// - a duty write in the overflow cycle may load a wrong value, wrong until the next interrupt.
// - entering the stop power state clears the run bit, halting the timer.
module tpw_top
  import tpw_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // wishbone slave
  input wire tpw_wb_req_t wb_req,
  output tpw_wb_rsp_t wb_rsp,
  // power management
  input wire logic stop_power_req,
  // outputs
  output logic pwm_out_n,
  output logic timer_irq
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic run_r;
  logic run_nxt;
  logic [2:0] clk_sel_r;
  logic [2:0] clk_sel_nxt;
  logic [2:0] mode_r;
  logic [2:0] mode_nxt;
  logic [7:0] duty_r;
  logic [7:0] duty_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  tpw_phase_t phase_r;
  tpw_phase_t phase_nxt;
  logic pwm_out_n_r;
  logic pwm_out_n_nxt;

  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;

  logic req;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_duty;
  logic wr_stat;
  logic wr_mask;
  logic start;
  logic active;
  logic tick;
  logic ovf;
  logic match;

  // ==========================================================================
  // wishbone decode
  // ==========================================================================
  // a write takes effect on the edge where the master samples ack high
  assign req = wb_req.cyc && wb_req.stb;
  assign wr_fire = req && wb_req.we && ack_r && wb_req.sel[0];
  assign wr_ctrl = wr_fire && (wb_req.adr == ADR_CTRL);
  assign wr_duty = wr_fire && (wb_req.adr == ADR_DUTY);
  assign wr_stat = wr_fire && (wb_req.adr == ADR_STAT);
  assign wr_mask = wr_fire && (wb_req.adr == ADR_MASK);

  // start is the 0 to 1 step of the run bit
  assign start = wr_ctrl && wb_req.dat[CTRL_RUN_BIT] && !run_r && !stop_power_req;

  // ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_nxt = req && !ack_r;
  end

  // read data captured in the request cycle and held with ack
  always_comb begin
    rdat_nxt = rdat_r;
    if (req && !ack_r) begin
      case (wb_req.adr)
        ADR_CTRL: rdat_nxt = {25'h0000000, mode_r, clk_sel_r, run_r};
        ADR_DUTY: rdat_nxt = {24'h000000, duty_r};
        ADR_STAT: rdat_nxt = {24'h000000, stat_r};
        ADR_MASK: rdat_nxt = {24'h000000, mask_r};
        ADR_CNT: rdat_nxt = {15'h0000, pwm_out_n_r, shift_r, cnt_r};
        default: rdat_nxt = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      rdat_r <= RD_UNMAPPED;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;

  // ==========================================================================
  // control, duty and mask registers
  // ==========================================================================
  // the stop power request is applied after any write so it always wins
  always_comb begin
    run_nxt = run_r;
    clk_sel_nxt = clk_sel_r;
    mode_nxt = mode_r;
    duty_nxt = duty_r;
    mask_nxt = mask_r;
    if (wr_ctrl) begin
      run_nxt = wb_req.dat[CTRL_RUN_BIT];
      clk_sel_nxt = wb_req.dat[CTRL_CLK_LSB +: 3];
      mode_nxt = wb_req.dat[CTRL_MODE_LSB +: 3];
    end
    if (wr_duty) begin
      duty_nxt = wb_req.dat[7:0];
    end
    if (wr_mask) begin
      mask_nxt = wb_req.dat[7:0];
    end
    if (stop_power_req) begin
      run_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_r <= CTRL_RST[CTRL_RUN_BIT];
      clk_sel_r <= CTRL_RST[CTRL_CLK_LSB +: 3];
      mode_r <= CTRL_RST[CTRL_MODE_LSB +: 3];
      duty_r <= DUTY_RST;
      mask_r <= MASK_RST;
    end else begin
      run_r <= run_nxt;
      clk_sel_r <= clk_sel_nxt;
      mode_r <= mode_nxt;
      duty_r <= duty_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ==========================================================================
  // source clock
  // ==========================================================================
  // only the pwm mode is built; any other mode leaves the timer standing
  assign active = run_r && (mode_r == MODE_PWM);

  tpw_prescaler u_presc (
    .mclk (mclk),
    .nrst (nrst),
    .en (active),
    .clear (start),
    .sel (clk_sel_r),
    .tick (tick)
  );

  // ==========================================================================
  // counter, compare shift register and pin
  // ==========================================================================
  assign ovf = active && run_nxt && tick && (cnt_r == CNT_MAX);
  assign match = active && run_nxt && tick && !ovf && ((cnt_r + 8'h01) == shift_r);

  // overflow wins over match; a duty of zero therefore never drives low
  always_comb begin
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    phase_nxt = phase_r;
    if (start) begin
      cnt_nxt = CNT_ZERO;
      shift_nxt = duty_r;
      phase_nxt = PH_HIGH;
    end else if (!run_nxt || !active) begin
      // a stop in the low phase cuts that period short
      cnt_nxt = CNT_ZERO;
      phase_nxt = PH_STOP;
    end else if (ovf) begin
      cnt_nxt = CNT_ZERO;
      phase_nxt = PH_HIGH;
      // a duty write in this very cycle is not seen; the old value moves
      shift_nxt = duty_r;
    end else if (tick) begin
      cnt_nxt = cnt_r + 8'h01;
      if (match) begin
        phase_nxt = PH_LOW;
      end
    end
  end

  // the pin is low only in the low phase; compare reads shift_r alone
  always_comb begin
    case (phase_nxt)
      PH_LOW: pwm_out_n_nxt = 1'b0;
      PH_HIGH: pwm_out_n_nxt = 1'b1;
      PH_STOP: pwm_out_n_nxt = 1'b1;
      default: pwm_out_n_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= CNT_ZERO;
      shift_r <= DUTY_RST;
      phase_r <= PH_STOP;
      pwm_out_n_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      phase_r <= phase_nxt;
      pwm_out_n_r <= pwm_out_n_nxt;
    end
  end

  assign pwm_out_n = pwm_out_n_r;

  // ==========================================================================
  // interrupt status
  // ==========================================================================
  // set wins over a same-cycle clear so no overflow is lost
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_r & ~wb_req.dat[7:0];
    end
    if (ovf) begin
      stat_nxt[STAT_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= 8'h00;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  assign timer_irq = |(stat_r & mask_r);

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_low_on_match: assert property (match |=> !pwm_out_n_r)
    else $error("pin not low after duty match");

  a_cnt_runs_on: assert property (match |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter did not advance on match");

  a_high_on_ovf: assert property (ovf |=> pwm_out_n_r && (cnt_r == CNT_ZERO))
    else $error("overflow did not restart period high at zero");

  a_ovf_sets_irq: assert property (ovf |=> stat_r[STAT_OVF_BIT])
    else $error("overflow did not set status");

  a_irq_src_ovf: assert property ($rose(stat_r[STAT_OVF_BIT]) |-> $past(ovf))
    else $error("status set without overflow");

  a_stop_high: assert property (!run_r |-> pwm_out_n_r)
    else $error("pin low while stopped");

  a_shift_holds: assert property (!start && !ovf |=> shift_r == $past(shift_r))
    else $error("compare value changed inside a period");

  a_shift_on_ovf: assert property (ovf |=> shift_r == $past(duty_r))
    else $error("duty not moved at period end");

  a_start_load: assert property (start |=> shift_r == $past(duty_r) && cnt_r == CNT_ZERO)
    else $error("start did not load duty and clear counter");

  a_start_high: assert property (start |=> pwm_out_n_r [*2])
    else $error("first period did not begin high");

  a_stop_power: assert property (stop_power_req |=> !run_r)
    else $error("stop power state left run bit set");

  a_ack_pulse: assert property (ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");

  c_start: cover property (start);
  c_match: cover property (match);
  c_ovf: cover property (ovf);
  c_duty_collide: cover property (ovf && wr_duty);

endmodule

// ### sim/tb.sv
// self-checking testbench of the timer pwm block
`timescale 1ns/1ps
module tb;
  import tpw_pkg::*;
  // run, clock code 5 (one tick per 4 mclk), pwm mode
  localparam logic [31:0] RUN_CFG = 32'h0000_003B;
  localparam logic [31:0] HALT_CFG = 32'h0000_003A;
  // stopped on the external source code, pwm mode; and stopped on code 5, mode 0
  localparam logic [31:0] EXT_HALT = 32'h0000_003E;
  localparam logic [31:0] OFF_HALT = 32'h0000_000A;
  logic mclk;
  logic nrst;
  logic stop_power_req;
  tpw_wb_req_t req;
  tpw_wb_rsp_t rsp;
  logic pwm_out_n;
  logic timer_irq;
  logic [15:0] low_len;
  logic [31:0] rd;
  int mismatches;
  int cmp_count;

  tpw_top uut (.mclk(mclk), .nrst(nrst), .wb_req(req), .wb_rsp(rsp),
    .stop_power_req(stop_power_req), .pwm_out_n(pwm_out_n), .timer_irq(timer_irq));
  tpw_pin_monitor mon (.mclk(mclk), .nrst(nrst), .pwm_out_n(pwm_out_n), .low_len(low_len));

  // ==========================================================================
  // clock, shared tasks
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic wishbone cycle; read data lands in rd at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) check("bus ack", 32'h0, 32'h1);
    rd = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  // bounded wait for a pin level, plus one edge so the meter has latched
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (pwm_out_n !== lvl && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) check("pin wait", 32'h0, 32'h1);
    @(posedge mclk);
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset;
    check("pin idle", 32'(pwm_out_n), 32'h1);
    check("irq idle", 32'(timer_irq), 32'h0);
    bus(1'b0, ADR_CTRL, 32'h0);
    check("ctrl rst", rd, {24'h0, CTRL_RST});
    bus(1'b0, ADR_DUTY, 32'h0);
    check("duty rst", rd, {24'h0, DUTY_RST});
    bus(1'b0, ADR_MASK, 32'h0);
    check("mask rst", rd, {24'h0, MASK_RST});
    bus(1'b0, ADR_STAT, 32'h0);
    check("stat rst", rd, 32'h0);
    bus(1'b1, 8'h20, 32'hFF);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, RD_UNMAPPED);
  endtask

  // clock code 5 is legal at any fast clock rate, unlike code 6
  task automatic t_start;
    bus(1'b1, ADR_DUTY, 32'h10);
    bus(1'b1, ADR_CTRL, RUN_CFG);
    bus(1'b0, ADR_CNT, 32'h0);
    check("cmp at start", {24'h0, rd[15:8]}, 32'h10);
    check("pin at start", 32'(rd[CNT_PIN_BIT]), 32'h1);
    check("cnt at start", 32'(rd[7:0] < 8'h08), 32'h1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    check("low len 10", {16'h0, low_len}, 32'h0000_03C0);
  endtask

  // duty written mid-period, well away from the boundary
  task automatic t_update;
    wait_pin(1'b0);
    bus(1'b1, ADR_DUTY, 32'h40);
    bus(1'b0, ADR_CNT, 32'h0);
    check("cmp held", {24'h0, rd[15:8]}, 32'h10);
    wait_pin(1'b1);
    check("low len kept", {16'h0, low_len}, 32'h0000_03C0);
    bus(1'b0, ADR_CNT, 32'h0);
    check("cmp moved", {24'h0, rd[15:8]}, 32'h40);
    wait_pin(1'b0);
    wait_pin(1'b1);
    check("low len 40", {16'h0, low_len}, 32'h0000_0300);
  endtask

  task automatic t_irq;
    bus(1'b1, ADR_STAT, 32'h1);
    bus(1'b1, ADR_MASK, 32'h1);
    wait_pin(1'b0);
    check("irq at match", 32'(timer_irq), 32'h0);
    wait_pin(1'b1);
    check("irq at ovf", 32'(timer_irq), 32'h1);
    bus(1'b0, ADR_STAT, 32'h0);
    check("stat ovf", rd, 32'h1);
    bus(1'b1, ADR_STAT, 32'h1);
    @(posedge mclk);
    check("irq cleared", 32'(timer_irq), 32'h0);
    wait_pin(1'b0);
    bus(1'b0, ADR_STAT, 32'h0);
    check("stat at match", rd, 32'h0);
    bus(1'b1, ADR_MASK, 32'h0);
    wait_pin(1'b1);
    check("irq masked", 32'(timer_irq), 32'h0);
    bus(1'b0, ADR_STAT, 32'h0);
    check("stat masked", rd, 32'h1);
    bus(1'b1, ADR_STAT, 32'h1);
  endtask

  // stop keeps mode and clock fields unchanged
  task automatic t_stop;
    wait_pin(1'b0);
    bus(1'b1, ADR_CTRL, HALT_CFG);
    @(posedge mclk);
    check("pin on stop", 32'(pwm_out_n), 32'h1);
    wait_pin(1'b1);
    check("short low", 32'(low_len < 16'h0300), 32'h1);
    repeat (1200) @(posedge mclk);
    check("pin stopped", 32'(pwm_out_n), 32'h1);
    bus(1'b0, ADR_STAT, 32'h0);
    check("no ovf stopped", rd, 32'h0);
  endtask

  // stop power request stands in for entry to the stop state, never pwm in sleep
  task automatic t_power;
    bus(1'b1, ADR_DUTY, 32'h20);
    bus(1'b1, ADR_CTRL, RUN_CFG);
    bus(1'b0, ADR_CNT, 32'h0);
    check("cmp restart", {24'h0, rd[15:8]}, 32'h20);
    wait_pin(1'b0);
    stop_power_req <= 1'b1;
    @(posedge mclk);
    stop_power_req <= 1'b0;
    @(posedge mclk);
    check("pin power stop", 32'(pwm_out_n), 32'h1);
    bus(1'b0, ADR_CTRL, 32'h0);
    check("run cleared", {24'h0, rd[7:0]}, HALT_CFG);
  endtask

  // fields change only while stopped; a run with no internal tick must stand at zero
  task automatic t_standing;
    bus(1'b1, ADR_CTRL, EXT_HALT);
    bus(1'b1, ADR_CTRL, EXT_HALT | 32'h1);
    repeat (100) @(posedge mclk);
    bus(1'b0, ADR_CNT, 32'h0);
    check("cnt ext src", {24'h0, rd[7:0]}, {24'h0, CNT_ZERO});
    check("pin ext src", 32'(rd[CNT_PIN_BIT]), 32'h1);
    bus(1'b1, ADR_CTRL, EXT_HALT);
    bus(1'b1, ADR_CTRL, OFF_HALT);
    bus(1'b1, ADR_CTRL, OFF_HALT | 32'h1);
    repeat (100) @(posedge mclk);
    bus(1'b0, ADR_CNT, 32'h0);
    check("cnt off mode", {24'h0, rd[7:0]}, {24'h0, CNT_ZERO});
    check("pin off mode", 32'(rd[CNT_PIN_BIT]), 32'h1);
    bus(1'b1, ADR_CTRL, OFF_HALT);
    bus(1'b0, ADR_STAT, 32'h0);
    check("no ovf standing", rd, 32'h0);
  endtask

  // ==========================================================================
  // verdict, watchdog, main sequence
  // ==========================================================================
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the whole run needs about 7 periods of 1024 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    nrst = 1'b0;
    stop_power_req = 1'b0;
    req = '0;
    mismatches = 0;
    cmp_count = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_start;
    t_update;
    t_irq;
    t_stop;
    t_power;
    t_standing;
    tally_and_finish;
  end
endmodule

// ### sim/tpw_pin_monitor.sv
// receiving circuit on the pwm pin: measures the length of each low phase
`timescale 1ns/1ps
module tpw_pin_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // pin under watch
  input wire logic pwm_out_n,
  // last completed low phase, in mclk cycles
  output logic [15:0] low_len
);
  logic [15:0] cnt_r;

  // ==========================================================================
  // low phase meter
  // ==========================================================================
  // latch only on the return high, so a phase still running never shows
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
      low_len <= 16'h0000;
    end else if (pwm_out_n == 1'b0) begin
      cnt_r <= cnt_r + 16'h0001;
    end else if (cnt_r != 16'h0000) begin
      low_len <= cnt_r;
      cnt_r <= 16'h0000;
    end
  end
endmodule
